// file: ocp_regs.vh
// Purpose: register map and constants of the compare channel
// Assumes: byte-addressed avalon slave, 32-bit data, byte offsets below
// Notes:   one word per register, unused upper bits read as zero
`ifndef OCP_REGS_VH
`define OCP_REGS_VH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define OCP_OFS_CTRL      6'h00
`define OCP_OFS_PRI       6'h04
`define OCP_OFS_SEC       6'h08
`define OCP_OFS_PER1      6'h0C
`define OCP_OFS_PER2      6'h10
`define OCP_OFS_TBCTL     6'h14
`define OCP_OFS_STAT      6'h18
`define OCP_OFS_MASK      6'h1C
`define OCP_OFS_CNT1      6'h20
`define OCP_OFS_CNT2      6'h24

// ----------------------------------------
// control register fields
// ----------------------------------------
`define OCP_CTRL_MODE_LSB 0
`define OCP_CTRL_MODE_MSB 2
`define OCP_CTRL_TBSEL    3
`define OCP_CTRL_FAULT    4
`define OCP_CTRL_RESET    16'h0000

// ----------------------------------------
// mode field encodings
// ----------------------------------------
`define OCP_MODE_OFF      3'h0
`define OCP_MODE_OS_LO    3'h1
`define OCP_MODE_OS_HI    3'h2
`define OCP_MODE_TOGGLE   3'h3
`define OCP_MODE_DLY_OS   3'h4
`define OCP_MODE_CONT     3'h5
`define OCP_MODE_PWM      3'h6
`define OCP_MODE_PWM_FLT  3'h7

// ----------------------------------------
// status and mask bits
// ----------------------------------------
`define OCP_ST_RISE       0
`define OCP_ST_FALL       1
`define OCP_ST_FAULT      2
`define OCP_ST_W          3

// ----------------------------------------
// reset values
// ----------------------------------------
`define OCP_PER_RESET     16'hFFFF
`define OCP_TB_RESET      2'h0

`endif

// file: ocp_sync.v
// Purpose: two-flop synchroniser for pin inputs
// Assumes: single clock mclk
// Notes:   first stage is read only by the second stage
`timescale 1ns/1ps
module ocp_sync (
	mclk,
	resetn,
	async_i,
	sync_o
);
	input  wire mclk;
	input  wire resetn;
	input  wire async_i;
	output reg  sync_o;

	reg meta_q;

	// ----------------------------------------
	// two-stage capture
	// ----------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			meta_q <= 1'b1;
			sync_o <= 1'b1;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end
endmodule // ocp_sync

// file: ocp_timebase.v
// Purpose: one 16-bit time base with period rollover
// Assumes: enable is a one-cycle pulse or a level from the bus side
// Notes:   count wraps to zero after matching the period
`timescale 1ns/1ps
module ocp_timebase #(
	parameter W = 16
) (
	mclk,
	resetn,
	run,
	period,
	count,
	wrap
);
	input  wire         mclk;
	input  wire         resetn;
	input  wire         run;
	input  wire [W-1:0] period;
	output reg  [W-1:0] count;
	output reg          wrap;

	// ----------------------------------------
	// counter
	// ----------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			count <= {W{1'b0}};
			wrap  <= 1'b0;
		end else begin
			wrap <= 1'b0;
			if (run) begin
				if (count == period) begin
					count <= {W{1'b0}};
					wrap  <= 1'b1;
				end else begin
					count <= count + {{(W-1){1'b0}}, 1'b1};
				end
			end
		end
	end
endmodule // ocp_timebase

// file: ocp_channel.v
// What this block does
// - time base chosen by select bit
// - compare primary, or primary and secondary
// - match changes pin per mode
// - mode zero disables, releases pin, pin_o tracks port
// - one-shots start low/high, edge interrupts
// - toggle keeps level, match inverts
// - toggle interrupts on both edges
// - delayed/continuous start low, falling interrupt
// - pwm start level from primary zero
// - plain pwm ignores fault, no interrupt
// - fault falling edge interrupts, sets flag
// - interrupt on mode-chosen pin edge
//
// Purpose: output compare / pwm channel with avalon-mm register slave
// Assumes: mclk 40 MHz; fault pin asynchronous, synchronised here
// Notes:   two internal time bases stand in for the shared timers
`timescale 1ns/1ps
`include "ocp_regs.vh"
module ocp_channel #(
	parameter W = 16
) (
	mclk,
	resetn,
	avs_address,
	avs_read,
	avs_write,
	avs_writedata,
	avs_readdata,
	avs_waitrequest,
	fault_input_a_n,
	gpio_level,
	compare_output_pin_o,
	compare_output_pin_oe,
	irq
);
	input  wire        mclk;
	input  wire        resetn;
	input  wire [5:0]  avs_address;
	input  wire        avs_read;
	input  wire        avs_write;
	input  wire [31:0] avs_writedata;
	output reg  [31:0] avs_readdata;
	output reg         avs_waitrequest;
	input  wire        fault_input_a_n;
	input  wire        gpio_level;
	output reg         compare_output_pin_o;
	output reg         compare_output_pin_oe;
	output reg         irq;

	// ----------------------------------------
	// registers
	// ----------------------------------------
	reg  [2:0]           compare_mode_field_q;
	reg                  timebase_select_q;
	reg                  fault_status_flag_q;
	reg  [W-1:0]         primary_compare_value_q;
	reg  [W-1:0]         secondary_compare_value_q;
	reg  [W-1:0]         duty_q;
	reg  [W-1:0]         period_first_q;
	reg  [W-1:0]         period_second_q;
	reg  [1:0]           tb_run_q;
	reg  [`OCP_ST_W-1:0] status_q;
	reg  [`OCP_ST_W-1:0] mask_q;
	reg                  pin_q;
	reg                  done_q;
	reg                  fault_q;
	reg                  gpio_q;
	reg                  flt_prev_q;
	reg                  ack_q;
	reg  [1:0]           run_prev_q;

	wire [W-1:0] cnt_first;
	wire [W-1:0] cnt_second;
	wire         wrap_first;
	wire         wrap_second;
	wire         flt_s;
	wire         gpio_s;

	// ----------------------------------------
	// time bases and synchronisers
	// ----------------------------------------
	ocp_timebase #(.W(W)) u_tb_first (
		.mclk   (mclk),
		.resetn (resetn),
		.run    (tb_run_q[0]),
		.period (period_first_q),
		.count  (cnt_first),
		.wrap   (wrap_first)
	);

	ocp_timebase #(.W(W)) u_tb_second (
		.mclk   (mclk),
		.resetn (resetn),
		.run    (tb_run_q[1]),
		.period (period_second_q),
		.count  (cnt_second),
		.wrap   (wrap_second)
	);

	ocp_sync u_sync_flt (
		.mclk    (mclk),
		.resetn  (resetn),
		.async_i (fault_input_a_n),
		.sync_o  (flt_s)
	);

	ocp_sync u_sync_gpio (
		.mclk    (mclk),
		.resetn  (resetn),
		.async_i (gpio_level),
		.sync_o  (gpio_s)
	);

	// ----------------------------------------
	// time base selection and matches
	// ----------------------------------------
	// select counter by bit
	wire [W-1:0] tb_cnt  = timebase_select_q ? cnt_second : cnt_first;
	wire         tb_wrap = timebase_select_q ? wrap_second : wrap_first;
	// a held count must not match again, toggle would run away
	wire         fresh   = timebase_select_q ? run_prev_q[1] : run_prev_q[0];
	wire         m_pri   = fresh & (tb_cnt == primary_compare_value_q);
	wire         m_sec   = fresh & (tb_cnt == secondary_compare_value_q);
	wire         m_duty  = fresh & (tb_cnt == duty_q);
	wire         is_pwm  = compare_mode_field_q[2] & compare_mode_field_q[1];
	wire         flt_fall = flt_prev_q & ~flt_s;

	// bus decode
	wire wr_ctrl = avs_write & (avs_address == `OCP_OFS_CTRL);
	wire rd_stat = avs_read & (avs_address == `OCP_OFS_STAT) & ~ack_q;

	// ----------------------------------------
	// next pin level per mode
	// ----------------------------------------
	reg pin_d;
	reg done_d;
	always @* begin
		pin_d  = pin_q;
		done_d = done_q;
		case (compare_mode_field_q)
		`OCP_MODE_OS_LO: begin
			if (m_pri && !done_q) begin
				pin_d  = 1'b1;
				done_d = 1'b1;
			end
		end
		`OCP_MODE_OS_HI: begin
			if (m_pri && !done_q) begin
				pin_d  = 1'b0;
				done_d = 1'b1;
			end
		end
		`OCP_MODE_TOGGLE: begin
			if (m_pri)
				pin_d = ~pin_q;
		end
		`OCP_MODE_DLY_OS, `OCP_MODE_CONT: begin
			// rise at primary, fall at secondary
			if (m_pri && !done_q)
				pin_d = 1'b1;
			else if (m_sec && pin_q) begin
				pin_d = 1'b0;
				if (compare_mode_field_q == `OCP_MODE_DLY_OS)
					done_d = 1'b1;
			end
		end
		`OCP_MODE_PWM, `OCP_MODE_PWM_FLT: begin
			if (tb_wrap)
				pin_d = (duty_q != {W{1'b0}});
			else if (m_duty)
				pin_d = 1'b0;
		end
		default: begin
			pin_d = pin_q;
		end
		endcase
	end

	// ----------------------------------------
	// channel state
	// ----------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			pin_q      <= 1'b0;
			done_q     <= 1'b0;
			fault_q    <= 1'b0;
			flt_prev_q <= 1'b1;
			gpio_q     <= 1'b0;
			duty_q     <= {W{1'b0}};
			run_prev_q <= 2'h0;
		end else begin
			flt_prev_q <= flt_s;
			gpio_q     <= gpio_s;
			run_prev_q <= tb_run_q;
			if (wr_ctrl && !avs_waitrequest) begin
				done_q  <= 1'b0;
				// rewrite of mode lifts fault hold
				// a fault in the same cycle still sets it
				fault_q <= flt_fall
					& (compare_mode_field_q == `OCP_MODE_PWM_FLT);
				case (avs_writedata[2:0])
				`OCP_MODE_OS_LO:  pin_q <= 1'b0;
				`OCP_MODE_OS_HI:  pin_q <= 1'b1;
				`OCP_MODE_TOGGLE: pin_q <= pin_q;
				`OCP_MODE_DLY_OS: pin_q <= 1'b0;
				`OCP_MODE_CONT:   pin_q <= 1'b0;
				`OCP_MODE_PWM, `OCP_MODE_PWM_FLT: begin
					pin_q  <= (primary_compare_value_q != {W{1'b0}});
					duty_q <= primary_compare_value_q;
				end
				default: pin_q <= gpio_q;
				endcase
			end else begin
				pin_q  <= pin_d;
				done_q <= done_d;
				if (is_pwm && tb_wrap)
					duty_q <= secondary_compare_value_q;
				if (compare_mode_field_q == `OCP_MODE_PWM_FLT && flt_fall)
					fault_q <= 1'b1;
				if (compare_mode_field_q == `OCP_MODE_OFF)
					pin_q <= gpio_q;
			end
		end
	end

	// ----------------------------------------
	// events and interrupt status
	// ----------------------------------------
	wire pin_rise = ~pin_q & pin_d;
	wire pin_fall = pin_q & ~pin_d;
	reg  [`OCP_ST_W-1:0] ev;
	always @* begin
		ev = {`OCP_ST_W{1'b0}};
		case (compare_mode_field_q)
		`OCP_MODE_OS_LO:  ev[`OCP_ST_RISE] = pin_rise;
		`OCP_MODE_OS_HI:  ev[`OCP_ST_FALL] = pin_fall;
		`OCP_MODE_TOGGLE: begin
			ev[`OCP_ST_RISE] = pin_rise;
			ev[`OCP_ST_FALL] = pin_fall;
		end
		`OCP_MODE_DLY_OS, `OCP_MODE_CONT: ev[`OCP_ST_FALL] = pin_fall;
		`OCP_MODE_PWM_FLT: ev[`OCP_ST_FAULT] = flt_fall;
		default: ev = {`OCP_ST_W{1'b0}};
		endcase
	end

	// ----------------------------------------
	// avalon-mm slave, one wait state
	// ----------------------------------------
	// ack_q marks the answer cycle; waitrequest low only then
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			compare_mode_field_q      <= 3'h0;
			timebase_select_q         <= 1'b0;
			primary_compare_value_q   <= {W{1'b0}};
			secondary_compare_value_q <= {W{1'b0}};
			period_first_q            <= `OCP_PER_RESET;
			period_second_q           <= `OCP_PER_RESET;
			tb_run_q                  <= `OCP_TB_RESET;
			status_q                  <= {`OCP_ST_W{1'b0}};
			mask_q                    <= {`OCP_ST_W{1'b0}};
			ack_q                     <= 1'b0;
			avs_waitrequest           <= 1'b1;
			avs_readdata              <= 32'h0000_0000;
			fault_status_flag_q       <= 1'b0;
		end else begin
			ack_q           <= (avs_read | avs_write) & ~ack_q;
			avs_waitrequest <= ~((avs_read | avs_write) & ~ack_q);
			fault_status_flag_q <= fault_q;
			// read clears status, new events win
			if (rd_stat)
				status_q <= ev;
			else
				status_q <= status_q | ev;
			if (avs_read && !ack_q) begin
				case (avs_address)
				`OCP_OFS_CTRL: avs_readdata <= {27'h0, fault_status_flag_q,
					timebase_select_q, compare_mode_field_q};
				`OCP_OFS_PRI:  avs_readdata <= {16'h0, primary_compare_value_q};
				`OCP_OFS_SEC:  avs_readdata <= {16'h0,
					secondary_compare_value_q};
				`OCP_OFS_PER1: avs_readdata <= {16'h0, period_first_q};
				`OCP_OFS_PER2: avs_readdata <= {16'h0, period_second_q};
				`OCP_OFS_TBCTL: avs_readdata <= {30'h0, tb_run_q};
				`OCP_OFS_STAT: avs_readdata <= {29'h0, status_q};
				`OCP_OFS_MASK: avs_readdata <= {29'h0, mask_q};
				`OCP_OFS_CNT1: avs_readdata <= {16'h0, cnt_first};
				`OCP_OFS_CNT2: avs_readdata <= {16'h0, cnt_second};
				default:       avs_readdata <= 32'h0000_0000;
				endcase
			end
			// caller stops timer; no interlock here
			if (avs_write && !ack_q) begin
				case (avs_address)
				`OCP_OFS_CTRL: begin
					compare_mode_field_q <= avs_writedata[2:0];
					timebase_select_q    <= avs_writedata[`OCP_CTRL_TBSEL];
				end
				`OCP_OFS_PRI:   primary_compare_value_q <= avs_writedata[15:0];
				`OCP_OFS_SEC:   secondary_compare_value_q <= avs_writedata[15:0];
				`OCP_OFS_PER1:  period_first_q <= avs_writedata[15:0];
				`OCP_OFS_PER2:  period_second_q <= avs_writedata[15:0];
				`OCP_OFS_TBCTL: tb_run_q <= avs_writedata[1:0];
				`OCP_OFS_MASK:  mask_q <= avs_writedata[2:0];
				default: ;
				endcase
			end
		end
	end

	// ----------------------------------------
	// registered outputs
	// ----------------------------------------
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			compare_output_pin_o  <= 1'b0;
			compare_output_pin_oe <= 1'b0;
			irq                   <= 1'b0;
		end else begin
			compare_output_pin_o  <= pin_q;
			compare_output_pin_oe <= (compare_mode_field_q != `OCP_MODE_OFF)
				& ~fault_q;
			irq <= |(status_q & mask_q);
		end
	end
endmodule // ocp_channel

// file: ocp_channel_chk.sv
// Purpose: port checks of the compare channel
// Assumes: mode and mask mirrored from accepted bus writes
// Notes:   checks wait three quiet cycles after a bus answer, start/keep three cycles after a control write
`timescale 1ns/1ps
module ocp_channel_chk (
	input wire        mclk,
	input wire        resetn,
	input wire [5:0]  avs_address,
	input wire        avs_write,
	input wire [31:0] avs_writedata,
	input wire        avs_waitrequest,
	input wire        fault_input_a_n,
	input wire        compare_output_pin_o,
	input wire        compare_output_pin_oe,
	input wire        irq
);
	// ----------------------------------------
	// mirrors and checks
	// ----------------------------------------
	reg  [2:0] mode_q;
	reg  [2:0] mask_q;
	reg  [3:0] sc_q;
	reg  [3:0] csc_q;
	wire       acc = avs_write && !avs_waitrequest;
	// quiet bus only, so a pending rewrite never trips a check
	wire       qt = sc_q > 4'h2 && avs_waitrequest;
	wire       pin = compare_output_pin_o;
	wire       oe = compare_output_pin_oe;
	wire       flt = fault_input_a_n;
	always @(posedge mclk or negedge resetn) begin
		if (!resetn) begin
			mode_q <= 3'h0;
			mask_q <= 3'h0;
			sc_q <= 4'h0;
			csc_q <= 4'h0;
		end else begin
			sc_q <= avs_waitrequest ? sc_q + {3'h0, sc_q != 4'hF} : 4'h0;
			csc_q <= csc_q + {3'h0, csc_q != 4'hF};
			if (acc && avs_address == 6'h00) begin
				mode_q <= avs_writedata[2:0];
				csc_q <= 4'h0;
			end
			if (acc && avs_address == 6'h1C)
				mask_q <= avs_writedata[2:0];
		end
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!resetn);
	property p_off; qt && mode_q == 3'h0 |-> !oe; endproperty
	a_off: assert property (p_off) else $error("pin driven while off");
	property p_start; csc_q == 4'h3 && mode_q inside {3'h1, 3'h2, 3'h4, 3'h5}
		|-> pin == (mode_q == 3'h2); endproperty
	a_start: assert property (p_start) else $error("start level");
	property p_keep; csc_q == 4'h3 && mode_q == 3'h3 |-> pin == $past(pin, 5);
	endproperty
	a_keep: assert property (p_keep) else $error("toggle entry level");
	property p_nofl; qt && mode_q == 3'h6 |-> oe; endproperty
	a_nofl: assert property (p_nofl) else $error("plain pwm released");
	property p_noirq; qt && mode_q == 3'h6 |-> !$rose(irq); endproperty
	a_noirq: assert property (p_noirq) else $error("plain pwm irq");
	property p_fltoe; qt && mode_q == 3'h7 && $fell(flt) |-> ##[1:6] !oe;
	endproperty
	a_fltoe: assert property (p_fltoe) else $error("fault not released");
	property p_hold; qt && mode_q == 3'h7 && !oe |=> !oe; endproperty
	a_hold: assert property (p_hold) else $error("fault hold lost");
	property p_fltirq; qt && mode_q == 3'h7 && mask_q[2] && $fell(flt)
		|-> ##[1:8] irq; endproperty
	a_fltirq: assert property (p_fltirq) else $error("no fault irq");
	property p_edge; qt && (mask_q[0] && $rose(pin) && mode_q inside {3'h1, 3'h3}
		|| mask_q[1] && $fell(pin) && mode_q inside {3'h2, 3'h3, 3'h4, 3'h5})
		|-> ##[0:4] irq; endproperty
	a_edge: assert property (p_edge) else $error("no edge irq");
endmodule // ocp_channel_chk
bind ocp_channel ocp_channel_chk u_chk (.mclk(mclk), .resetn(resetn),
	.avs_address(avs_address), .avs_write(avs_write),
	.avs_writedata(avs_writedata), .avs_waitrequest(avs_waitrequest),
	.fault_input_a_n(fault_input_a_n),
	.compare_output_pin_o(compare_output_pin_o),
	.compare_output_pin_oe(compare_output_pin_oe), .irq(irq));

// file: ocp_pin_load.sv
// Purpose: load on the compare pin with edge and pulse counters
// Assumes: a pull-down resistor holds the released line low
// Notes:   width keeps the last complete high pulse in mclk cycles
`timescale 1ns/1ps
module ocp_pin_load (
	input  wire mclk,
	input  wire pin_o,
	input  wire pin_oe,
	output wire pin_lvl,
	output int  n_rise,
	output int  width
);
	// ----------------------------------------
	// line level and pulse counters
	// ----------------------------------------
	int run = 0;
	reg prev_q = 1'h0;
	// released line falls to the pull-down level
	assign pin_lvl = pin_oe ? pin_o : 1'h0;
	initial n_rise = 0;
	initial width = 0;
	always @(posedge mclk) begin
		prev_q <= pin_lvl;
		if (pin_lvl && !prev_q)
			n_rise <= n_rise + 1;
		if (pin_lvl)
			run <= run + 1;
		else if (run != 0)
			width <= run;
		if (!pin_lvl)
			run <= 0;
	end
endmodule // ocp_pin_load

// file: output_compare_pwm_channel_bench.sv
// Purpose: self-checking bench of the compare channel
// Assumes: mclk 40 MHz, bus answers after one wait state
// Notes:   timers stopped around every control write
`timescale 1ns/1ps
`include "ocp_regs.vh"
module output_compare_pwm_channel_bench;
	// ----------------------------------------
	// stimulus and scenarios
	// ----------------------------------------
	reg         mclk = 1'h0;
	reg         resetn = 1'h0;
	reg  [5:0]  avs_address = 6'h00;
	reg         avs_read = 1'h0;
	reg         avs_write = 1'h0;
	reg  [31:0] avs_writedata = 32'h0;
	reg         fault_n = 1'h1;
	reg         gpio = 1'h0;
	reg  [31:0] q;
	reg         b;
	wire [31:0] rdata;
	wire        wreq;
	wire        pin_o;
	wire        pin_oe;
	wire        irq;
	wire        pin_lvl;
	int         n_rise;
	int         width;
	int         k;
	int         n_errors = 0;
	int         tests_run = 0;
	always #12.5 mclk = ~mclk;
	ocp_channel #(.W(16)) DUT (.mclk(mclk), .resetn(resetn),
		.avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(rdata), .avs_waitrequest(wreq),
		.fault_input_a_n(fault_n), .gpio_level(gpio),
		.compare_output_pin_o(pin_o), .compare_output_pin_oe(pin_oe),
		.irq(irq));
	ocp_pin_load u_load (.mclk(mclk), .pin_o(pin_o), .pin_oe(pin_oe),
		.pin_lvl(pin_lvl), .n_rise(n_rise), .width(width));
	task end_sim;
		if (n_errors == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input [31:0] got, input [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
			n_errors++;
		end
	endtask
	task bus(input w, input [5:0] a, input [31:0] d);
		@(posedge mclk);
		avs_address <= a;
		avs_write <= w;
		avs_read <= !w;
		avs_writedata <= d;
		// only the watchdog ends a wait
		do
			@(posedge mclk);
		while (wreq !== 1'h0);
		q = rdata;
		avs_write <= 1'h0;
		avs_read <= 1'h0;
		// answer stands one cycle only
		@(posedge mclk);
		chk(wreq, 32'h1);
	endtask
	task wr(input [5:0] a, input [31:0] d); bus(1'h1, a, d); endtask
	task rd(input [5:0] a, input [31:0] e); bus(1'h0, a, 0); chk(q, e); endtask
	task cyc(input int n); repeat (n) @(posedge mclk); endtask
	task halt_tb; wr(`OCP_OFS_TBCTL, 32'h0); cyc(8); endtask
	task cfg(input [31:0] c, input [31:0] p, input [31:0] s);
		wr(`OCP_OFS_TBCTL, 32'h0);
		wr(`OCP_OFS_PRI, p);
		wr(`OCP_OFS_SEC, s);
		wr(`OCP_OFS_CTRL, c);
		cyc(4);
		bus(1'h0, `OCP_OFS_STAT, 32'h0);
	endtask
	task t_regs;
		for (k = 0; k < 11; k++)
			rd(6'(k * 4), (k == 3 || k == 4) ? 32'hFFFF : 32'h0);
		wr(6'h28, 32'h5A5A);
		rd(6'h28, 32'h0);
		wr(`OCP_OFS_CTRL, 32'h10);
		rd(`OCP_OFS_CTRL, 32'h0);
		gpio <= 1'h1;
		cyc(8);
		chk({pin_oe, pin_o}, 32'h1);
	endtask
	task t_oneshot;
		cfg(32'h2, 32'h10, 32'h0);
		chk(pin_lvl, 32'h1);
		wr(`OCP_OFS_TBCTL, 32'h1);
		cyc(150);
		chk({irq, pin_lvl}, 32'h2);
		rd(`OCP_OFS_STAT, 32'h2);
		cyc(2);
		chk(irq, 32'h0);
		cfg(32'h9, 32'h10, 32'h0);
		chk(pin_lvl, 32'h0);
		wr(`OCP_OFS_TBCTL, 32'h1);
		cyc(150);
		chk(pin_lvl, 32'h0);
		wr(`OCP_OFS_TBCTL, 32'h2);
		cyc(150);
		chk(pin_lvl, 32'h1);
		rd(`OCP_OFS_STAT, 32'h1);
	endtask
	task t_toggle;
		cfg(32'h3, 32'h10, 32'h0);
		chk(pin_lvl, 32'h1);
		wr(`OCP_OFS_TBCTL, 32'h1);
		cyc(100);
		for (k = 0; k < 2; k++) begin
			b = pin_lvl;
			cyc(65);
			chk(pin_lvl, !b);
		end
		halt_tb;
		rd(`OCP_OFS_STAT, 32'h3);
	endtask
	task t_pulse;
		cfg(32'h4, 32'h10, 32'h20);
		chk(pin_lvl, 32'h0);
		k = n_rise;
		wr(`OCP_OFS_TBCTL, 32'h1);
		cyc(200);
		chk(n_rise - k, 32'h1);
		chk(width, 32'h10);
		halt_tb;
		rd(`OCP_OFS_STAT, 32'h2);
		cfg(32'h5, 32'h10, 32'h28);
		wr(`OCP_OFS_TBCTL, 32'h1);
		cyc(100);
		k = n_rise;
		cyc(195);
		chk(n_rise - k, 32'h3);
		chk(width, 32'h18);
		halt_tb;
		rd(`OCP_OFS_STAT, 32'h2);
	endtask
	task t_pwm;
		cfg(32'h6, 32'h0, 32'h18);
		chk(pin_lvl, 32'h0);
		cfg(32'h6, 32'h10, 32'h18);
		chk(pin_lvl, 32'h1);
		wr(`OCP_OFS_TBCTL, 32'h1);
		cyc(150);
		chk(width >= 32'h18 && width <= 32'h19, 32'h1);
		fault_n <= 1'h0;
		cyc(10);
		chk({irq, pin_oe}, 32'h1);
		wr(`OCP_OFS_SEC, 32'h8);
		cyc(150);
		chk(width >= 32'h8 && width <= 32'h9, 32'h1);
		fault_n <= 1'h1;
		halt_tb;
		rd(`OCP_OFS_STAT, 32'h0);
	endtask
	task t_fault;
		cfg(32'h7, 32'h10, 32'h18);
		wr(`OCP_OFS_TBCTL, 32'h1);
		cyc(20);
		fault_n <= 1'h0;
		cyc(10);
		chk({irq, pin_oe, pin_lvl}, 32'h4);
		rd(`OCP_OFS_CTRL, 32'h17);
		fault_n <= 1'h1;
		cyc(100);
		chk(pin_oe, 32'h0);
		halt_tb;
		rd(`OCP_OFS_STAT, 32'h4);
		cfg(32'h7, 32'h10, 32'h18);
		chk(pin_oe, 32'h1);
		rd(`OCP_OFS_CTRL, 32'h7);
		wr(`OCP_OFS_CTRL, 32'h0);
		cyc(4);
		chk(pin_oe, 32'h0);
	endtask
	initial begin
		repeat (3) @(posedge mclk);
		resetn <= 1'h1;
		t_regs;
		wr(`OCP_OFS_PER1, 32'h40);
		wr(`OCP_OFS_PER2, 32'h40);
		wr(`OCP_OFS_MASK, 32'h7);
		t_oneshot;
		t_toggle;
		t_pulse;
		t_pwm;
		t_fault;
		end_sim;
	end
	// about ten times the expected run
	initial begin
		#(25 * 20000);
		n_errors++;
		end_sim;
	end
endmodule // output_compare_pwm_channel_bench
